// >>> tdq_host_mem.sv
`timescale 1ns/1ns
module tdq_host_mem (
   input wire logic core_clk,
   input wire logic slow,
   input wire logic pq_rd_req,
   input wire logic [31:0] pq_rd_addr,
   output logic pq_rd_ack,
   output logic [31:0] pq_rd_data,
   input wire logic dq_wr_req,
   input wire logic [31:0] dq_wr_addr,
   input wire logic [31:0] dq_wr_data,
   output logic dq_wr_ack,
   output logic [31:0] last_addr,
   output logic [31:0] last_data,
   output int n_rd,
   output int n_wr
);
   logic [1:0] wait_q = 2'h0;
   initial begin
      {pq_rd_ack, dq_wr_ack, pq_rd_data, last_addr, last_data, n_rd, n_wr} = '0;
   end
   always @(posedge core_clk) begin
      pq_rd_ack <= 1'h0;
      dq_wr_ack <= 1'h0;
      wait_q <= wait_q + 2'h1;
      // Released data line toggles so a stale sample cannot pass
      pq_rd_data <= ~pq_rd_data;
      if (pq_rd_req && !pq_rd_ack && (!slow || wait_q == 2'h3)) begin
         pq_rd_ack <= 1'h1;
         pq_rd_data <= {6'h00, pq_rd_addr[3], 1'h0, 8'h00, pq_rd_addr[17:2]};
         n_rd <= n_rd + 1;
      end
      if (dq_wr_req && !dq_wr_ack && (!slow || wait_q == 2'h3)) begin
         dq_wr_ack <= 1'h1;
         last_addr <= dq_wr_addr;
         last_data <= dq_wr_data;
         n_wr <= n_wr + 1;
      end
   end
endmodule

// >>> tdq_pkg.sv
package tdq_pkg;

   // Register offsets (byte addresses on the register port)
   localparam logic [11:0] PEND_BASE_LO_OFS = 12'h800;
   localparam logic [11:0] PEND_BASE_HI_OFS = 12'h804;
   localparam logic [11:0] PEND_END_OFS = 12'h808;
   localparam logic [11:0] PEND_HOST_WR_OFS = 12'h80C;
   localparam logic [11:0] PEND_DMA_RD_OFS = 12'h810;
   localparam logic [11:0] DONE_BASE_LO_OFS = 12'h830;
   localparam logic [11:0] DONE_BASE_HI_OFS = 12'h834;
   localparam logic [11:0] DONE_END_OFS = 12'h838;
   localparam logic [11:0] DONE_HOST_RD_OFS = 12'h83C;
   localparam logic [11:0] DONE_DMA_WR_OFS = 12'h840;
   localparam logic [11:0] TX_QUEUE_CTRL_OFS = 12'h880;
   localparam logic [11:0] DMA_STATUS_OFS = 12'h890;
   localparam logic [11:0] DMA_IRQ_EN_OFS = 12'h894;
   localparam logic [11:0] DMA_MASTER_OFS = 12'h898;

   // Reset values
   localparam logic [15:0] REG16_RST = 16'h0000;
   localparam logic [2:0] STATUS_RST = 3'h0;

   // Queue control field positions
   localparam int CTRL_PREFETCH_EN_BIT = 0;
   localparam int CTRL_PREFETCH_FLUSH_BIT = 1;
   localparam int CTRL_DONE_BURST_EN_BIT = 2;
   localparam int CTRL_DONE_BURST_FLUSH_BIT = 3;
   localparam int CTRL_THRESH_LSB = 8;
   localparam int CTRL_THRESH_MSB = 10;
   localparam logic [15:0] CTRL_WR_MASK = 16'h070F;

   // Status flag positions
   localparam int STAT_PEND_READ_BIT = 0;
   localparam int STAT_DONE_WRITE_BIT = 1;
   localparam int STAT_DONE_WERR_BIT = 2;

   // Master enable bit position
   localparam int MASTER_TX_EN_BIT = 0;

   // Prefetch FIFO geometry
   localparam int PREFETCH_DEPTH = 16;
   localparam int PREFETCH_AW = 4;
   localparam int ENTRY_W = 32;

   // Queue entry field layout
   localparam int ENT_INDEX_LSB = 0;
   localparam int ENT_INDEX_MSB = 15;
   localparam int ENT_CHAN_LSB = 16;
   localparam int ENT_CHAN_MSB = 23;
   localparam int ENT_REVIVE_BIT = 25;
   localparam int ENT_STATUS_LSB = 26;

   // Completion and error codes
   localparam logic [2:0] ST_PACKET_DONE = 3'h0;
   localparam logic [2:0] ST_ERR_NOT_ENABLED = 3'h4;
   localparam logic [2:0] ST_ERR_DESCRIPTOR = 3'h5;
   localparam logic [2:0] ST_ERR_PCI = 3'h6;
   localparam logic [2:0] ST_ERR_UNDERFLOW = 3'h7;

   typedef enum logic [1:0] {
      PF_IDLE = 2'b00,
      PF_CHECK = 2'b01,
      PF_READ = 2'b11
   } tdq_pf_state_t;

   typedef enum logic [1:0] {
      DN_IDLE = 2'b00,
      DN_WRITE = 2'b01
   } tdq_dn_state_t;

endpackage

// >>> tdq_prefetch_fifo.sv
`timescale 1ns/1ns
module tdq_prefetch_fifo (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic flush,
   input wire logic push,
   input wire logic [tdq_pkg::ENTRY_W-1:0] din,
   input wire logic pop,
   output logic [tdq_pkg::ENTRY_W-1:0] dout,
   output logic empty,
   output logic full
);

   logic [tdq_pkg::ENTRY_W-1:0] mem_q [tdq_pkg::PREFETCH_DEPTH];
   logic [tdq_pkg::PREFETCH_AW-1:0] wr_q;
   logic [tdq_pkg::PREFETCH_AW-1:0] rd_q;
   logic [tdq_pkg::PREFETCH_AW:0] cnt_q;
   logic do_push;
   logic do_pop;

   assign empty = (cnt_q == '0);
   assign full = (cnt_q == (tdq_pkg::PREFETCH_AW+1)'(tdq_pkg::PREFETCH_DEPTH));
   assign do_push = push && !full && !flush;
   assign do_pop = pop && !empty && !flush;
   assign dout = mem_q[rd_q];

   always_ff @(posedge core_clk) begin
      if (do_push) begin
         mem_q[wr_q] <= din;
      end
   end

   // Flush drops every held entry
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else if (flush) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (do_push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (do_pop) begin
            rd_q <= rd_q + 1'b1;
         end
         case ({do_push, do_pop})
            2'b10: cnt_q <= cnt_q + 1'b1;
            2'b01: cnt_q <= cnt_q - 1'b1;
            default: cnt_q <= cnt_q;
         endcase
      end
   end

endmodule

// >>> tdq_queue_dma.sv
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ns
module tdq_queue_dma (
   input wire logic core_clk,
   input wire logic rst_n,
   // Register port
   input wire logic [11:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Pending-queue read master
   output logic pq_rd_req,
   output logic [31:0] pq_rd_addr,
   input wire logic pq_rd_ack,
   input wire logic [31:0] pq_rd_data,
   // Pending entries to the descriptor walker
   output logic pend_entry_valid,
   output logic [31:0] pend_entry_data,
   input wire logic pend_entry_ready,
   output logic chan_revive,
   // Completion requests from the transmit engine
   input wire logic done_valid,
   output logic done_ready,
   input wire logic [15:0] done_index,
   input wire logic [7:0] done_chan,
   input wire logic done_per_buffer,
   input wire logic [1:0] done_buf_pos,
   input wire logic done_error,
   input wire logic [1:0] done_err_code,
   // Done-queue write master
   output logic dq_wr_req,
   output logic [31:0] dq_wr_addr,
   output logic [31:0] dq_wr_data,
   input wire logic dq_wr_ack,
   // Channel error handling and interrupt
   output logic chan_abort,
   output logic chan_out_of_service,
   output logic [7:0] chan_err_num,
   output logic irq
);

   // Registers
   logic [15:0] pend_base_lo_q;
   logic [15:0] pend_base_hi_q;
   logic [15:0] pend_end_offset_q;
   logic [15:0] pend_host_wr_ptr_q;
   logic [15:0] pend_dma_rd_ptr_q;
   logic [15:0] done_base_lo_q;
   logic [15:0] done_base_hi_q;
   logic [15:0] done_end_offset_q;
   logic [15:0] done_host_rd_ptr_q;
   logic [15:0] done_dma_wr_ptr_q;
   logic [15:0] tx_queue_ctrl_q;
   logic [2:0] dma_status_reg_q;
   logic [2:0] irq_en_q;
   logic tx_dma_enable_q;
   logic [31:0] reg_rdata_q;

   logic pend_prefetch_en;
   logic pend_prefetch_flush;
   logic [2:0] done_flag_threshold;

   // Pending fetch
   tdq_pkg::tdq_pf_state_t pf_state_q;
   logic [4:0] burst_left_q;
   logic [16:0] pend_avail;
   logic [4:0] burst_len;
   logic [15:0] pend_rd_next;
   logic fifo_empty;
   logic fifo_pop;
   logic pend_read_flag_set;

   // Done writer
   tdq_pkg::tdq_dn_state_t dn_state_q;
   logic [31:0] dq_wr_data_q;
   logic [15:0] done_wr_next;
   logic done_full;
   logic done_accept;
   logic [2:0] done_code;
   logic [7:0] thresh_cnt_q;
   logic [7:0] thresh_target;
   logic done_write_flag_set;
   logic done_write_error_flag_set;
   logic chan_abort_q;
   logic chan_out_of_service_q;
   logic [7:0] chan_err_num_q;
   logic chan_revive_q;

   logic wr_hit;
   logic [2:0] status_clr;

   assign pend_prefetch_en = tx_queue_ctrl_q[tdq_pkg::CTRL_PREFETCH_EN_BIT];
   assign pend_prefetch_flush = tx_queue_ctrl_q[tdq_pkg::CTRL_PREFETCH_FLUSH_BIT];
   assign done_flag_threshold = tx_queue_ctrl_q[tdq_pkg::CTRL_THRESH_MSB:tdq_pkg::CTRL_THRESH_LSB];

   // ---------------------------------------------------------------- register writes
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_base_lo_q <= tdq_pkg::REG16_RST;
         pend_base_hi_q <= tdq_pkg::REG16_RST;
         pend_end_offset_q <= tdq_pkg::REG16_RST;
         pend_host_wr_ptr_q <= tdq_pkg::REG16_RST;
         done_base_lo_q <= tdq_pkg::REG16_RST;
         done_base_hi_q <= tdq_pkg::REG16_RST;
         done_end_offset_q <= tdq_pkg::REG16_RST;
         done_host_rd_ptr_q <= tdq_pkg::REG16_RST;
         tx_queue_ctrl_q <= tdq_pkg::REG16_RST;
         irq_en_q <= tdq_pkg::STATUS_RST;
         tx_dma_enable_q <= 1'b0;
      end else if (reg_wr) begin
         case (reg_addr)
            tdq_pkg::PEND_BASE_LO_OFS: pend_base_lo_q <= reg_wdata[15:0];
            tdq_pkg::PEND_BASE_HI_OFS: pend_base_hi_q <= reg_wdata[15:0];
            tdq_pkg::PEND_END_OFS: pend_end_offset_q <= reg_wdata[15:0];
            tdq_pkg::PEND_HOST_WR_OFS: pend_host_wr_ptr_q <= reg_wdata[15:0];
            tdq_pkg::DONE_BASE_LO_OFS: done_base_lo_q <= reg_wdata[15:0];
            tdq_pkg::DONE_BASE_HI_OFS: done_base_hi_q <= reg_wdata[15:0];
            tdq_pkg::DONE_END_OFS: done_end_offset_q <= reg_wdata[15:0];
            tdq_pkg::DONE_HOST_RD_OFS: done_host_rd_ptr_q <= reg_wdata[15:0];
            tdq_pkg::TX_QUEUE_CTRL_OFS: tx_queue_ctrl_q <= reg_wdata[15:0] & tdq_pkg::CTRL_WR_MASK;
            tdq_pkg::DMA_IRQ_EN_OFS: irq_en_q <= reg_wdata[2:0];
            tdq_pkg::DMA_MASTER_OFS: tx_dma_enable_q <= reg_wdata[tdq_pkg::MASTER_TX_EN_BIT];
            default: ;
         endcase
      end
   end

   // ---------------------------------------------------------------- register reads
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_q <= '0;
      end else if (reg_rd) begin
         case (reg_addr)
            tdq_pkg::PEND_BASE_LO_OFS: reg_rdata_q <= {16'h0000, pend_base_lo_q};
            tdq_pkg::PEND_BASE_HI_OFS: reg_rdata_q <= {16'h0000, pend_base_hi_q};
            tdq_pkg::PEND_END_OFS: reg_rdata_q <= {16'h0000, pend_end_offset_q};
            tdq_pkg::PEND_HOST_WR_OFS: reg_rdata_q <= {16'h0000, pend_host_wr_ptr_q};
            tdq_pkg::PEND_DMA_RD_OFS: reg_rdata_q <= {16'h0000, pend_dma_rd_ptr_q};
            tdq_pkg::DONE_BASE_LO_OFS: reg_rdata_q <= {16'h0000, done_base_lo_q};
            tdq_pkg::DONE_BASE_HI_OFS: reg_rdata_q <= {16'h0000, done_base_hi_q};
            tdq_pkg::DONE_END_OFS: reg_rdata_q <= {16'h0000, done_end_offset_q};
            tdq_pkg::DONE_HOST_RD_OFS: reg_rdata_q <= {16'h0000, done_host_rd_ptr_q};
            tdq_pkg::DONE_DMA_WR_OFS: reg_rdata_q <= {16'h0000, done_dma_wr_ptr_q};
            tdq_pkg::TX_QUEUE_CTRL_OFS: reg_rdata_q <= {16'h0000, tx_queue_ctrl_q};
            tdq_pkg::DMA_STATUS_OFS: reg_rdata_q <= {29'h0, dma_status_reg_q};
            tdq_pkg::DMA_IRQ_EN_OFS: reg_rdata_q <= {29'h0, irq_en_q};
            tdq_pkg::DMA_MASTER_OFS: reg_rdata_q <= {31'h0, tx_dma_enable_q};
            default: reg_rdata_q <= '0;
         endcase
      end else begin
         reg_rdata_q <= '0;
      end
   end

   assign reg_rdata = reg_rdata_q;

   // ---------------------------------------------------------------- status and interrupt
   assign wr_hit = reg_wr && (reg_addr == tdq_pkg::DMA_STATUS_OFS);
   assign status_clr = wr_hit ? reg_wdata[2:0] : 3'h0;

   // Write one to clear; a new event in the same cycle wins
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         dma_status_reg_q <= tdq_pkg::STATUS_RST;
      end else begin
         dma_status_reg_q[tdq_pkg::STAT_PEND_READ_BIT] <=
            pend_read_flag_set | (dma_status_reg_q[tdq_pkg::STAT_PEND_READ_BIT] &
            ~status_clr[tdq_pkg::STAT_PEND_READ_BIT]);
         dma_status_reg_q[tdq_pkg::STAT_DONE_WRITE_BIT] <=
            done_write_flag_set | (dma_status_reg_q[tdq_pkg::STAT_DONE_WRITE_BIT] &
            ~status_clr[tdq_pkg::STAT_DONE_WRITE_BIT]);
         dma_status_reg_q[tdq_pkg::STAT_DONE_WERR_BIT] <=
            done_write_error_flag_set | (dma_status_reg_q[tdq_pkg::STAT_DONE_WERR_BIT] &
            ~status_clr[tdq_pkg::STAT_DONE_WERR_BIT]);
      end
   end

   assign irq = |(dma_status_reg_q & irq_en_q);

   // ---------------------------------------------------------------- pending queue fetch
   // Entries available between read and host write pointer, across the wrap
   always_comb begin
      if (pend_host_wr_ptr_q >= pend_dma_rd_ptr_q) begin
         pend_avail = {1'b0, pend_host_wr_ptr_q - pend_dma_rd_ptr_q};
      end else begin
         pend_avail = 17'({1'b0, pend_end_offset_q} - {1'b0, pend_dma_rd_ptr_q} + 17'h00001
            + {1'b0, pend_host_wr_ptr_q});
      end
   end

   always_comb begin
      if (!pend_prefetch_en) begin
         burst_len = 5'h01;
      end else if (pend_avail >= 17'(tdq_pkg::PREFETCH_DEPTH)) begin
         burst_len = 5'(tdq_pkg::PREFETCH_DEPTH);
      end else begin
         burst_len = pend_avail[4:0];
      end
   end

   // End is an offset; pointer wraps to zero after reading at it
   assign pend_rd_next = (pend_dma_rd_ptr_q >= pend_end_offset_q) ? 16'h0000 :
      16'(pend_dma_rd_ptr_q + 16'h0001);

   assign pq_rd_req = (pf_state_q == tdq_pkg::PF_READ);
   assign pq_rd_addr = 32'({pend_base_hi_q, pend_base_lo_q} + {14'h0, pend_dma_rd_ptr_q, 2'b00});
   assign pend_read_flag_set = pq_rd_req && pq_rd_ack;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pf_state_q <= tdq_pkg::PF_IDLE;
         burst_left_q <= 5'h00;
      end else begin
         case (pf_state_q)
            tdq_pkg::PF_IDLE: begin
               if (tx_dma_enable_q && fifo_empty && !pend_prefetch_flush) begin
                  pf_state_q <= tdq_pkg::PF_CHECK;
               end
            end
            tdq_pkg::PF_CHECK: begin
               if (pend_avail == 17'h00000) begin
                  pf_state_q <= tdq_pkg::PF_IDLE;
               end else begin
                  burst_left_q <= burst_len;
                  pf_state_q <= tdq_pkg::PF_READ;
               end
            end
            tdq_pkg::PF_READ: begin
               if (pq_rd_ack) begin
                  burst_left_q <= burst_left_q - 5'h01;
                  if (burst_left_q == 5'h01) begin
                     pf_state_q <= tdq_pkg::PF_IDLE;
                  end
               end
            end
            default: pf_state_q <= tdq_pkg::PF_IDLE;
         endcase
      end
   end

   // Host may write the read pointer at any time; a fetch acknowledge in the same cycle wins
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_dma_rd_ptr_q <= tdq_pkg::REG16_RST;
      end else if (pend_read_flag_set) begin
         pend_dma_rd_ptr_q <= pend_rd_next;
      end else if (reg_wr && reg_addr == tdq_pkg::PEND_DMA_RD_OFS) begin
         pend_dma_rd_ptr_q <= reg_wdata[15:0];
      end
   end

   tdq_prefetch_fifo u_prefetch (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .flush(pend_prefetch_flush),
      .push(pend_read_flag_set),
      .din(pq_rd_data),
      .pop(fifo_pop),
      .dout(pend_entry_data),
      .empty(fifo_empty),
      .full()
   );

   assign pend_entry_valid = !fifo_empty && !pend_prefetch_flush;
   assign fifo_pop = pend_entry_valid && pend_entry_ready;

   // Revive pulse follows one cycle after the pop of the entry that carries it
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         chan_revive_q <= 1'b0;
      end else begin
         chan_revive_q <= fifo_pop && pend_entry_data[tdq_pkg::ENT_REVIVE_BIT];
      end
   end

   assign chan_revive = chan_revive_q;

   // ---------------------------------------------------------------- done queue writer
   assign done_wr_next = (done_dma_wr_ptr_q >= done_end_offset_q) ? 16'h0000 :
      16'(done_dma_wr_ptr_q + 16'h0001);
   assign done_full = (done_wr_next == done_host_rd_ptr_q);
   assign done_ready = (dn_state_q == tdq_pkg::DN_IDLE) && tx_dma_enable_q;
   assign done_accept = done_valid && done_ready;

   always_comb begin
      if (done_error) begin
         done_code = {1'b1, done_err_code};
      end else if (done_per_buffer) begin
         done_code = {1'b0, done_buf_pos};
      end else begin
         done_code = tdq_pkg::ST_PACKET_DONE;
      end
   end

   assign done_write_error_flag_set = done_accept && done_full;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         dn_state_q <= tdq_pkg::DN_IDLE;
         dq_wr_data_q <= '0;
      end else begin
         case (dn_state_q)
            tdq_pkg::DN_IDLE: begin
               if (done_accept && !done_full) begin
                  dq_wr_data_q <= {3'h0, done_code, 2'b00, done_chan, done_index};
                  dn_state_q <= tdq_pkg::DN_WRITE;
               end
            end
            tdq_pkg::DN_WRITE: begin
               if (dq_wr_ack) begin
                  dn_state_q <= tdq_pkg::DN_IDLE;
               end
            end
            default: dn_state_q <= tdq_pkg::DN_IDLE;
         endcase
      end
   end

   assign dq_wr_req = (dn_state_q == tdq_pkg::DN_WRITE);
   assign dq_wr_data = dq_wr_data_q;
   assign dq_wr_addr = 32'({done_base_hi_q, done_base_lo_q} + {14'h0, done_dma_wr_ptr_q, 2'b00});

   // Host may write the done write pointer only while the done writer is idle
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         done_dma_wr_ptr_q <= tdq_pkg::REG16_RST;
      end else if (dq_wr_req && dq_wr_ack) begin
         done_dma_wr_ptr_q <= done_wr_next;
      end else if (reg_wr && reg_addr == tdq_pkg::DONE_DMA_WR_OFS && dn_state_q == tdq_pkg::DN_IDLE) begin
         done_dma_wr_ptr_q <= reg_wdata[15:0];
      end
   end

   // Threshold 0 flags every write, n flags every 2**n writes
   assign thresh_target = 8'(8'h01 << done_flag_threshold);
   assign done_write_flag_set = dq_wr_req && dq_wr_ack &&
      ((done_flag_threshold == 3'h0) || (8'(thresh_cnt_q + 8'h01) == thresh_target));

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         thresh_cnt_q <= 8'h00;
      end else if (dq_wr_req && dq_wr_ack) begin
         if (done_write_flag_set) begin
            thresh_cnt_q <= 8'h00;
         end else begin
            thresh_cnt_q <= 8'(thresh_cnt_q + 8'h01);
         end
      end
   end

   // Errors abort the frame and drop the channel out of service
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         chan_abort_q <= 1'b0;
         chan_out_of_service_q <= 1'b0;
         chan_err_num_q <= 8'h00;
      end else begin
         chan_abort_q <= done_accept && done_error;
         chan_out_of_service_q <= done_accept && done_error;
         if (done_accept && done_error) begin
            chan_err_num_q <= done_chan;
         end
      end
   end

   assign chan_abort = chan_abort_q;
   assign chan_out_of_service = chan_out_of_service_q;
   assign chan_err_num = chan_err_num_q;

endmodule

// >>> tdq_queue_dma_bench.sv
`timescale 1ns/1ns
module tdq_queue_dma_bench;
   logic core_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, pend_entry_ready = 0, done_valid = 0, slow = 0;
   logic done_per_buffer = 0, done_error = 0;
   logic [11:0] reg_addr = 0;
   logic [31:0] reg_wdata = 0, sd = 32'h9254;
   logic [15:0] done_index = 0, wp = 0;
   logic [7:0] done_chan = 0, chan_err_num;
   logic [1:0] done_buf_pos = 0, done_err_code = 0;
   logic [31:0] reg_rdata, pq_rd_addr, pq_rd_data, pend_entry_data, dq_wr_addr, dq_wr_data, last_addr, last_data;
   logic pq_rd_req, pq_rd_ack, pend_entry_valid, chan_revive, done_ready, dq_wr_req, dq_wr_ack, chan_abort;
   logic chan_out_of_service, irq;
   int n_rd, n_wr, err_count = 0, n_compared = 0, k;
   always #4 core_clk = ~core_clk;
   tdq_queue_dma tdq_queue_dma_inst (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .pq_rd_req, .pq_rd_addr, .pq_rd_ack, .pq_rd_data, .pend_entry_valid, .pend_entry_data, .pend_entry_ready,
      .chan_revive, .done_valid, .done_ready, .done_index, .done_chan, .done_per_buffer, .done_buf_pos,
      .done_error, .done_err_code, .dq_wr_req, .dq_wr_addr, .dq_wr_data, .dq_wr_ack, .chan_abort,
      .chan_out_of_service, .chan_err_num, .irq);
   tdq_host_mem tdq_host_mem_inst (.core_clk, .slow, .pq_rd_req, .pq_rd_addr, .pq_rd_ack, .pq_rd_data,
      .dq_wr_req, .dq_wr_addr, .dq_wr_data, .dq_wr_ack, .last_addr, .last_data, .n_rd, .n_wr);
   function logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task complete_run;
      $display("Compared %0d, errors %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task tmo(input int i);
      if (i >= 300) begin
         err_count++;
         $display("[FAIL] %0t wait timed out", $time);
         complete_run();
      end
   endtask
   task wr(input logic [11:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= {16'h0000, d};
      reg_wr <= 1'h1;
      @(posedge core_clk);
      reg_wr <= 1'h0;
      @(negedge core_clk);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] exp);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge core_clk);
      reg_rd <= 1'h0;
      @(negedge core_clk);
      chk(reg_rdata, exp);
   endtask
   task wait_cnt(input int want, input logic side);
      int i;
      i = 0;
      while ((side ? n_wr : n_rd) != want && i < 300) begin
         @(negedge core_clk);
         i++;
      end
      tmo(i);
   endtask
   task pop(input logic [15:0] exp);
      int i;
      i = 0;
      while (pend_entry_valid !== 1'h1 && i < 300) begin
         @(negedge core_clk);
         i++;
      end
      tmo(i);
      chk({16'h0000, pend_entry_data[15:0]}, {16'h0000, exp});
      @(posedge core_clk);
      pend_entry_ready <= 1'h1;
      @(posedge core_clk);
      pend_entry_ready <= 1'h0;
      @(negedge core_clk);
   endtask
   task done_tx(input logic [2:0] kind, input logic [15:0] idx, input logic [7:0] ch);
      int i;
      @(posedge core_clk);
      done_index <= idx;
      done_chan <= ch;
      done_per_buffer <= !kind[2] && kind[1:0] != 2'h0;
      done_buf_pos <= kind[1:0];
      done_error <= kind[2];
      done_err_code <= kind[1:0];
      done_valid <= 1'h1;
      i = 0;
      do begin
         @(negedge core_clk);
         i++;
      end while (done_ready !== 1'h1 && i < 300);
      tmo(i);
      @(posedge core_clk);
      done_valid <= 1'h0;
   endtask
   initial begin
      repeat (6) @(posedge core_clk);
      rst_n <= 1'h1;
      rd(tdq_pkg::TX_QUEUE_CTRL_OFS, 32'h0);
      rd(12'hFFC, 32'h0);
      sd = lfsr(sd);
      wr(tdq_pkg::PEND_END_OFS, sd[15:0]);
      rd(tdq_pkg::PEND_END_OFS, {16'h0000, sd[15:0]});
      wr(tdq_pkg::PEND_BASE_LO_OFS, 16'h1000);
      wr(tdq_pkg::PEND_BASE_HI_OFS, 16'h0001);
      wr(tdq_pkg::PEND_END_OFS, 16'h0005);
      wr(tdq_pkg::PEND_HOST_WR_OFS, 16'h0003);
      wr(tdq_pkg::DMA_IRQ_EN_OFS, 16'h0001);
      repeat (20) @(negedge core_clk);
      chk(n_rd, 0);
      wr(tdq_pkg::DMA_MASTER_OFS, 16'h0001);
      for (k = 0; k < 3; k++) pop(16'h4400 + k[15:0]);
      rd(tdq_pkg::PEND_DMA_RD_OFS, 32'h3);
      chk({31'h0, irq}, 32'h1);
      wr(tdq_pkg::DMA_STATUS_OFS, 16'h0007);
      chk({31'h0, irq}, 32'h0);
      slow <= 1'h1;
      wr(tdq_pkg::TX_QUEUE_CTRL_OFS, 16'h0001);
      wr(tdq_pkg::PEND_HOST_WR_OFS, 16'h0002);
      wait_cnt(8, 1'h0);
      repeat (30) @(negedge core_clk);
      chk(n_rd, 8);
      for (k = 0; k < 5; k++) pop(16'h4400 + 16'((3 + k) % 6));
      rd(tdq_pkg::PEND_DMA_RD_OFS, 32'h2);
      wr(tdq_pkg::PEND_HOST_WR_OFS, 16'h0004);
      wait_cnt(10, 1'h0);
      chk({31'h0, pend_entry_valid}, 32'h1);
      wr(tdq_pkg::TX_QUEUE_CTRL_OFS, 16'h0003);
      chk({31'h0, pend_entry_valid}, 32'h0);
      wr(tdq_pkg::TX_QUEUE_CTRL_OFS, 16'h0001);
      repeat (20) @(negedge core_clk);
      chk(n_rd, 10);
      slow <= 1'h0;
      wr(tdq_pkg::DONE_BASE_HI_OFS, 16'h0002);
      wr(tdq_pkg::DONE_END_OFS, 16'h0003);
      wr(tdq_pkg::TX_QUEUE_CTRL_OFS, 16'h0701);
      wr(tdq_pkg::DMA_STATUS_OFS, 16'h0007);
      for (k = 0; k < 8; k++) begin
         sd = lfsr(sd);
         done_tx(k[2:0], sd[15:0], sd[23:16]);
         wait_cnt(k + 1, 1'h1);
         chk(last_addr, 32'h0002_0000 + {wp, 2'h0});
         chk(last_data & 32'hFCFF_FFFF, {3'h0, k[2:0], 2'h0, sd[23:0]});
         wp = (wp >= 16'h3) ? 16'h0 : wp + 16'h1;
         wr(tdq_pkg::DONE_HOST_RD_OFS, wp);
      end
      rd(tdq_pkg::DONE_DMA_WR_OFS, {16'h0000, wp});
      rd(tdq_pkg::DMA_STATUS_OFS, 32'h0);
      wr(tdq_pkg::DONE_HOST_RD_OFS, (wp + 16'h1) % 16'h4);
      done_tx(3'h0, 16'h00A5, 8'h01);
      repeat (10) @(negedge core_clk);
      chk(n_wr, 8);
      rd(tdq_pkg::DMA_STATUS_OFS, 32'h4);
      complete_run();
   end
endmodule

// >>> tdq_queue_dma_properties.sv
`timescale 1ns/1ns
module tdq_queue_dma_checker (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic pq_rd_req,
   input wire logic [31:0] pq_rd_addr,
   input wire logic pq_rd_ack,
   input wire logic pend_entry_valid,
   input wire logic [31:0] pend_entry_data,
   input wire logic pend_entry_ready,
   input wire logic chan_revive,
   input wire logic done_valid,
   input wire logic done_ready,
   input wire logic [15:0] done_index,
   input wire logic [7:0] done_chan,
   input wire logic done_per_buffer,
   input wire logic [1:0] done_buf_pos,
   input wire logic done_error,
   input wire logic [1:0] done_err_code,
   input wire logic dq_wr_req,
   input wire logic [31:0] dq_wr_addr,
   input wire logic [31:0] dq_wr_data,
   input wire logic dq_wr_ack,
   input wire logic chan_abort,
   input wire logic chan_out_of_service,
   input wire logic [7:0] chan_err_num
);
   logic [2:0] st;
   assign st = done_error ? {1'h1, done_err_code} : (done_per_buffer ? {1'h0, done_buf_pos} : 3'h0);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   a_pend_req_hold: assert property (pq_rd_req && !pq_rd_ack |=> pq_rd_req && $stable(pq_rd_addr))
      else $error("pending read request dropped or moved");
   a_push_shows: assert property (pq_rd_req && pq_rd_ack |=> pend_entry_valid)
      else $error("fetched entry not offered");
   a_done_hold: assert property (dq_wr_req && !dq_wr_ack |=> dq_wr_req && $stable(dq_wr_data) && $stable(dq_wr_addr))
      else $error("done write dropped or moved");
   a_burst_start: assert property ($rose(pq_rd_req) |-> !pend_entry_valid)
      else $error("fetch started while FIFO holds entries");
   a_done_entry: assert property (done_valid && done_ready ##1 dq_wr_req |->
      dq_wr_data[23:0] == {$past(done_chan), $past(done_index)} && dq_wr_data[31:26] == {3'h0, $past(st)})
      else $error("done entry fields wrong");
   a_error_abort: assert property (done_valid && done_ready && done_error |=>
      chan_abort && chan_out_of_service && chan_err_num == $past(done_chan))
      else $error("error completion without abort");
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
      else $error("read data outside read slot");
   a_revive_pulse: assert property (pend_entry_valid && pend_entry_ready && pend_entry_data[25] |=> chan_revive)
      else $error("revive bit not acted on");
   c_burst: cover property (pq_rd_ack ##[1:8] pq_rd_ack);
   c_err_write: cover property (done_valid && done_ready && done_error ##1 dq_wr_req);
   c_revive: cover property (chan_revive);
endmodule

bind tdq_queue_dma tdq_queue_dma_checker tdq_queue_dma_checker_inst (.core_clk, .rst_n, .reg_rd, .reg_rdata,
   .pq_rd_req, .pq_rd_addr, .pq_rd_ack, .pend_entry_valid, .pend_entry_data, .pend_entry_ready, .chan_revive,
   .done_valid, .done_ready, .done_index, .done_chan, .done_per_buffer, .done_buf_pos, .done_error,
   .done_err_code, .dq_wr_req, .dq_wr_addr, .dq_wr_data, .dq_wr_ack, .chan_abort, .chan_out_of_service,
   .chan_err_num);
